/* File: common/fadr_map.svh */
`ifndef FADR_MAP_SVH
`define FADR_MAP_SVH
// register byte offsets
`define FADR_CTRL_OFS 12'h000
`define FADR_STATUS_OFS 12'h004
`define FADR_COUNT_OFS 12'h008
`define FADR_RESLO_OFS 12'h00c
`define FADR_RESHI_OFS 12'h010
// control field positions and reset value
`define FADR_CTRL_EN_BIT 0
`define FADR_CTRL_RST 32'h0000_0001
// status field positions
`define FADR_ST_OVF_BIT 0
`define FADR_ST_B96_BIT 1
`define FADR_ST_INC_BIT 2
`define FADR_ST_VLD_BIT 3
// datapath figures
`define FADR_SEC_W 9
`define FADR_LAST_W 7
`define FADR_SECTIONS 11
`define FADR_COEF_W 97
`define FADR_EXP_BIAS 11'h400
`define FADR_EXP_NEG_ONE 11'h7fe
// cycles from accepted start to written result
`define FADR_LATENCY 2
`endif

/* File: common/fadr_pkg.sv */
package fadr_pkg;
  // operands as they leave alignment
  typedef struct packed {
    logic [95:0] ref_coef;
    logic [95:0] shf_coef;
    logic ref_sign;
    logic shf_sign;
    logic [10:0] exponent;
  } fadr_op_t;
  // first-stage partial sum
  typedef struct packed {
    logic [96:0] bit_en;
    logic [96:0] bit_br;
    logic [21:0] grp_en;
    logic [21:0] grp_br;
    logic [10:0] sec_en;
    logic [10:0] sec_br;
  } fadr_psum_t;
  // output sample controls
  typedef struct packed {
    logic upper;
    logic center;
    logic lower;
    logic expo;
    logic dp;
  } fadr_samp_t;
endpackage

/* File: rtl/fadr_top.sv */
`timescale 1ns/10ps
`include "fadr_map.svh"
module fadr_top import fadr_pkg::*; #(
  parameter int SEC_W = `FADR_SEC_W,
  parameter int LAST_W = `FADR_LAST_W,
  parameter int SECTIONS = `FADR_SECTIONS
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic i_special_case,
  input wire logic i_double_precision_select,
  input wire fadr_op_t i_op,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [59:0] o_result,
  output logic o_result_valid
);
  // the datapath is wired for exactly this split
  if (SEC_W != 9 || LAST_W != 7 || SECTIONS != 11 ||
      (SECTIONS - 1) * SEC_W + LAST_W != `FADR_COEF_W) begin : g_chk
    $error("fadr_top: section geometry not supported");
  end

  logic [31:0] ctrl;
  logic [31:0] count;
  logic st_ovf, st_b96, st_inc;
  fadr_psum_t psum, next_psum;
  fadr_samp_t samp, next_samp;
  logic op_sign_a, op_sign_b;
  logic [10:0] op_exp;
  logic stage2;
  logic [96:0] opa, opb;
  logic [96:0] carry, sum, coef;
  logic eac, b96, ovf, inc_path;
  logic [47:0] lo_part, up_part, ce_part;
  logic [10:0] exp_inc;
  logic [11:0] exp_field;
  logic [59:0] next_result;
  logic accept;

  // operands widened with sign in bit 96, complemented on entry
  assign opa = ~{i_op.ref_sign, i_op.ref_coef};
  assign opb = ~{i_op.shf_sign, i_op.shf_coef};
  // software can stop the unit from taking new starts
  assign accept = i_start & ctrl[`FADR_CTRL_EN_BIT];

  // first stage: bit, group and section enables and borrows
  always_comb begin
    logic c;
    int b, w;
    c = 1'b0;
    b = 0;
    w = 0;
    next_psum = '0;
    next_psum.bit_en = opa ^ opb;
    next_psum.bit_br = opa & opb;
    for (int s = 0; s < SECTIONS; s++) begin
      b = s * SEC_W;
      w = (s == SECTIONS - 1) ? LAST_W : SEC_W;
      for (int k = 0; k < 2; k++) begin
        next_psum.grp_en[2*s+k] = &next_psum.bit_en[b+3*k +: 3];
        c = 1'b0;
        for (int j = 0; j < 3; j++) begin
          c = next_psum.bit_br[b+3*k+j] | (next_psum.bit_en[b+3*k+j] & c);
        end
        next_psum.grp_br[2*s+k] = c;
      end
      next_psum.sec_en[s] = 1'b1;
      c = 1'b0;
      for (int j = 0; j < SEC_W; j++) begin
        if (j < w) begin
          next_psum.sec_en[s] = next_psum.sec_en[s] & next_psum.bit_en[b+j];
          c = next_psum.bit_br[b+j] | (next_psum.bit_en[b+j] & c);
        end
      end
      next_psum.sec_br[s] = c;
    end
  end

  // sample controls raised only for a clean start
  always_comb begin
    next_samp = '0;
    if (accept && !i_special_case) begin
      next_samp.upper = !i_double_precision_select;
      next_samp.lower = i_double_precision_select;
      next_samp.center = 1'b1;
      next_samp.expo = 1'b1;
      next_samp.dp = i_double_precision_select;
    end
  end

  // partial sum and operation state held for the output period
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      psum <= '0;
      samp <= '0;
      op_sign_a <= 1'b0;
      op_sign_b <= 1'b0;
      op_exp <= 11'h000;
      stage2 <= 1'b0;
    end else begin
      psum <= next_psum;
      samp <= next_samp;
      op_sign_a <= i_op.ref_sign;
      op_sign_b <= i_op.shf_sign;
      op_exp <= i_op.exponent;
      stage2 <= accept;
    end
  end

  // second stage: section carries with end-around, then group and bit carries
  always_comb begin
    logic c, cg1, c6;
    int b, w;
    c = 1'b0;
    cg1 = 1'b0;
    c6 = 1'b0;
    b = 0;
    w = 0;
    for (int s = 0; s < SECTIONS; s++) begin
      c = psum.sec_br[s] | (psum.sec_en[s] & c);
    end
    eac = c;
    carry = '0;
    b96 = 1'b0;
    for (int s = 0; s < SECTIONS; s++) begin
      b = s * SEC_W;
      w = (s == SECTIONS - 1) ? LAST_W : SEC_W;
      cg1 = psum.grp_br[2*s] | (psum.grp_en[2*s] & c);
      c6 = psum.grp_br[2*s+1] | (psum.grp_en[2*s+1] & cg1);
      for (int j = 0; j < SEC_W; j++) begin
        if (j < w) begin
          if (j == 3) c = cg1;
          if (j == 6) c = c6;
          carry[b+j] = c;
          c = psum.bit_br[b+j] | (psum.bit_en[b+j] & c);
        end
      end
      if (s == SECTIONS - 1) b96 = c6;
      c = psum.sec_br[s] | (psum.sec_en[s] & carry[b]);
    end
    sum = psum.bit_en ^ carry;
  end

  // complementing network returns the coefficient to true form
  assign coef = ~sum;

  // overflow: like signs only; positive needs no borrow, negative needs one
  assign ovf = (op_sign_a == op_sign_b) && (op_sign_a ? b96 : !b96);

  // three output regions; ones where not sampled, ANDed like a wired net
  always_comb begin
    lo_part = '1;
    up_part = '1;
    ce_part = '1;
    for (int i = 0; i <= 44; i++) begin
      if (samp.lower) lo_part[i] = ovf ? coef[i+1] : coef[i];
    end
    for (int i = 54; i <= 95; i++) begin
      if (samp.upper) up_part[i-48] = ovf ? coef[i+1] : coef[i];
    end
    if (samp.center) begin
      if (samp.dp && ovf) ce_part[47:45] = coef[48:46];
      else if (ovf) ce_part[5:0] = coef[54:49];
      else if (samp.dp) ce_part[47:45] = coef[47:45];
      else ce_part[5:0] = coef[53:48];
    end
    // coef[0] under shift and coef[96] without shift never reach the output
  end

  // exponent: incrementing path or direct path, then bias, form and sign
  always_comb begin
    logic [10:0] e;
    e = 11'h000;
    inc_path = (op_sign_a == op_sign_b) ? ovf : b96;
    exp_inc = op_exp + {10'h000, ovf};
    if (ovf && op_exp == `FADR_EXP_NEG_ONE) exp_inc = 11'h000;
    e = inc_path ? exp_inc : op_exp;
    e = e ^ `FADR_EXP_BIAS;
    if ((op_sign_a && op_sign_b) || (op_sign_a != op_sign_b && b96)) begin
      exp_field = ~{1'b0, e};
    end else begin
      exp_field = {1'b0, e};
    end
    if (!samp.expo) exp_field = '1;
    next_result = {exp_field, lo_part & up_part & ce_part};
  end

  // destination word and its strobe
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_result <= '0;
      o_result_valid <= 1'b0;
    end else begin
      o_result_valid <= stage2;
      if (stage2) o_result <= next_result;
    end
  end

  // status and completion count for software
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ovf <= 1'b0;
      st_b96 <= 1'b0;
      st_inc <= 1'b0;
      count <= '0;
    end else if (stage2) begin
      st_ovf <= ovf;
      st_b96 <= b96;
      st_inc <= inc_path;
      count <= count + 32'h0000_0001;
    end
  end

  // apb slave: one wait state so read data leaves a flip-flop
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      ctrl <= `FADR_CTRL_RST;
    end else begin
      pready <= psel & penable & !pready;
      if (psel && penable && !pready) begin
        pslverr <= 1'b0;
        prdata <= '0;
        unique case (paddr)
          `FADR_CTRL_OFS: prdata <= ctrl;
          `FADR_STATUS_OFS: prdata <= {28'h0000000, o_result_valid, st_inc, st_b96, st_ovf};
          `FADR_COUNT_OFS: prdata <= count;
          `FADR_RESLO_OFS: prdata <= o_result[31:0];
          `FADR_RESHI_OFS: prdata <= {4'h0, o_result[59:32]};
          default: pslverr <= 1'b1;
        endcase
      end
      // write lands only at the completing edge
      if (psel && penable && pready && pwrite && paddr == `FADR_CTRL_OFS) begin
        ctrl <= {31'h00000000, pwdata[`FADR_CTRL_EN_BIT]};
      end
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  unlike_no_ovf_a: assert property (stage2 && op_sign_a != op_sign_b |-> !ovf)
    else $error("overflow with unlike signs");
  lat_two_a: assert property (accept |-> ##2 o_result_valid)
    else $error("result not written two cycles after start");
  exp_ones_a: assert property (accept && i_special_case |-> ##2 o_result[59:48] == 12'hfff)
    else $error("exponent not all ones without sampling");
  center_ones_a: assert property (accept && i_special_case |-> ##2 o_result[47:0] == '1)
    else $error("coefficient not all ones without sampling");
  samp_raise_a: assert property (accept && !i_special_case
      |=> samp.center && samp.expo && (samp.upper != samp.lower))
    else $error("sample controls not raised for clean start");
  sp_norm_a: assert property (stage2 && samp.upper && !ovf |=> o_result[47:0] == $past(coef[95:48]))
    else $error("single precision normal path wrong");
  dp_ovf_a: assert property (stage2 && samp.lower && ovf |=> o_result[47:0] == $past(coef[48:1]))
    else $error("double precision overflow path wrong");
  neg_zero_a: assert property (stage2 && samp.expo && ovf && !op_sign_a |=> o_result[59] == 1'b0)
    else $error("positive overflow exponent not positive");
  sum_check_a: assert property (stage2 |-> ovf == (op_sign_a == op_sign_b && (op_sign_a == b96)))
    else $error("overflow decision inconsistent");
  cov_sp_c: cover property (stage2 && samp.upper && ovf);
  cov_dp_c: cover property (stage2 && samp.lower && !ovf);
  cov_unlike_c: cover property (stage2 && op_sign_a != op_sign_b && b96);
  cov_apb_c: cover property (psel && penable && pready && !pwrite);
  cov_zero_c: cover property (stage2 && ovf && !op_sign_a && op_exp == `FADR_EXP_NEG_ONE);

  // exponent form per sign case other than both negative, rebuilt from the held operand exponent
  // a broken incrementer or complement network shows up here first
  exp_pos_a: assert property (stage2 && samp.expo && !op_sign_a && !op_sign_b
      && b96 |=> o_result[59:48] == {1'b0, $past(op_exp) ^ `FADR_EXP_BIAS})
    else $error("positive exponent without overflow wrong");
  exp_uplus_a: assert property (stage2 && samp.expo && op_sign_a != op_sign_b
      && !b96 |=> o_result[59:48] == {1'b0, $past(op_exp) ^ `FADR_EXP_BIAS})
    else $error("unlike signs positive exponent wrong");
  exp_uminus_a: assert property (stage2 && samp.expo && op_sign_a != op_sign_b
      && b96 |=> o_result[59:48] == ~{1'b0, $past(op_exp) ^ `FADR_EXP_BIAS})
    else $error("unlike signs negative exponent wrong");
  exp_inc_a: assert property (stage2 && samp.expo && !op_sign_a && !op_sign_b
      && !b96 && op_exp != `FADR_EXP_NEG_ONE
      |=> o_result[59:48] == {1'b0, 11'($past(op_exp) + 11'h001) ^ `FADR_EXP_BIAS})
    else $error("overflow exponent not incremented");
  exp_zero_a: assert property (stage2 && samp.expo && !op_sign_a && !op_sign_b
      && !b96 && op_exp == `FADR_EXP_NEG_ONE |=> o_result[59:48] == {1'b0, `FADR_EXP_BIAS})
    else $error("negative one plus one not positive zero");

  // coefficient paths and sample controls not covered above
  // each output path is checked once against the raw true-form sum
  sp_ovf_a: assert property (stage2 && samp.upper && ovf
      |=> o_result[47:0] == $past(coef[96:49]))
    else $error("single precision overflow path wrong");
  dp_norm_a: assert property (stage2 && samp.lower && !ovf
      |=> o_result[47:0] == $past(coef[47:0]))
    else $error("double precision normal path wrong");
  samp_dp_a: assert property (accept && !i_special_case
      |=> samp.dp == $past(i_double_precision_select) && samp.lower == samp.dp)
    else $error("precision not held with sample controls");
  samp_none_a: assert property (accept && i_special_case |=> samp == '0)
    else $error("sampling raised for special case");
  // sign bits alone decide the end-around borrow when signs are alike
  eac_pos_a: assert property (stage2 && !op_sign_a && !op_sign_b |-> eac)
    else $error("positive operands without end-around borrow");
  eac_neg_a: assert property (stage2 && op_sign_a && op_sign_b |-> !eac)
    else $error("negative operands with end-around borrow");
  gen_prop_a: assert property ((psum.bit_br & psum.bit_en) == '0)
    else $error("bit borrow and bit enable both set");
  stat_a: assert property (stage2 |=> st_ovf == $past(ovf) && st_b96 == $past(b96))
    else $error("status not taken from finished operation");
  count_a: assert property (stage2 |=> count == $past(count) + 32'h0000_0001)
    else $error("completion count not advanced");
  hold_a: assert property (!o_result_valid |-> $stable(o_result))
    else $error("result changed without strobe");

  // bus side: one wait state, writes only on the completing edge
  // a refused start must not raise stage2 on the next cycle
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  refuse_a: assert property (i_start && !ctrl[`FADR_CTRL_EN_BIT] |=> !stage2)
    else $error("start taken while disabled");
  ctrl_write_a: assert property (psel && penable && pready && pwrite && paddr == `FADR_CTRL_OFS
      |=> ctrl[`FADR_CTRL_EN_BIT] == $past(pwdata[`FADR_CTRL_EN_BIT]))
    else $error("control write not landed");
  slverr_a: assert property (psel && penable && !pready && paddr > `FADR_RESHI_OFS |=> pslverr)
    else $error("unmapped address without error");

  // per-section partial sum against its own bits; the last section is narrow
  // so its enable covers seven bits only
  for (genvar s = 0; s < SECTIONS; s++) begin : g_sec_chk
    localparam int SW = (s == SECTIONS - 1) ? LAST_W : SEC_W;
    sec_en_a: assert property (psum.sec_en[s] == &psum.bit_en[s*SEC_W +: SW])
      else $error("section enable not all bit enables");
    grp_lo_a: assert property (psum.grp_en[2*s] == &psum.bit_en[s*SEC_W +: 3])
      else $error("low group enable wrong");
    grp_hi_a: assert property (psum.grp_en[2*s+1] == &psum.bit_en[s*SEC_W+3 +: 3])
      else $error("high group enable wrong");
  end
endmodule

/* File: verif/fadr_dest_model.sv */
`timescale 1ns/10ps
// destination operand file: keeps the last delivered word and a write count
module fadr_dest_model (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_we,
  input wire logic [59:0] i_word,
  output logic [59:0] o_word,
  output logic [31:0] o_writes
);
  // one write per cycle that valid is high, so a stretched pulse shows up as extra writes
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_word <= 60'h0;
      o_writes <= 32'h0;
    end else if (i_we) begin
      o_word <= i_word;
      o_writes <= o_writes + 32'h1;
    end
  end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`include "fadr_map.svh"
module tb_top import fadr_pkg::*;;
  localparam int LAT = `FADR_LATENCY;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic i_start = 1'b0;
  logic i_special_case = 1'b0;
  logic i_double_precision_select = 1'b0;
  fadr_op_t i_op = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [59:0] o_result;
  logic o_result_valid;
  logic [59:0] dest_word;
  logic [31:0] dest_writes;
  logic [59:0] exp_q[$];
  int iss_q[$];
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_ops = 0;
  logic [3:0] last_st;
  logic [59:0] last_w;
  logic [31:0] rd;
  logic err;
  fadr_op_t ops[5];

  fadr_top i_dut (.i_clock, .i_rstn, .i_start, .i_special_case, .i_double_precision_select,
    .i_op, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .o_result, .o_result_valid);
  fadr_dest_model i_dest (.i_clock, .i_rstn, .i_we(o_result_valid), .i_word(o_result),
    .o_word(dest_word), .o_writes(dest_writes));

  // free-running clock and edge counter
  always #12.5 i_clock = ~i_clock;
  always @(posedge i_clock) cyc <= cyc + 1;

  // reference: ones-complement sum, output half select, exponent fixup
  function automatic logic [59:0] model(input fadr_op_t op, input logic dp, input logic sc,
                                        output logic [3:0] st);
    logic [97:0] r;
    logic [96:0] s;
    logic [96:0] t;
    logic ovf;
    logic neg;
    logic [10:0] e;
    logic [11:0] x;
    r = {1'b0, op.ref_sign, op.ref_coef} + {1'b0, op.shf_sign, op.shf_coef};
    s = r[96:0] + 97'(r[97]);
    t = {1'b0, ~op.ref_coef} + {1'b0, ~op.shf_coef};
    ovf = (op.ref_sign == op.shf_sign) && (op.ref_sign == t[96]);
    neg = (op.ref_sign & op.shf_sign) | ((op.ref_sign ^ op.shf_sign) & t[96]);
    e = op.exponent;
    if (ovf) e = (e == `FADR_EXP_NEG_ONE) ? 11'h000 : e + 11'h001;
    x = {1'b0, e ^ `FADR_EXP_BIAS};
    if (neg) x = ~x;
    st = {1'b0, ovf | ((op.ref_sign ^ op.shf_sign) & t[96]), t[96], ovf};
    if (sc) return '1;
    return {x, dp ? (ovf ? s[48:1] : s[47:0]) : (ovf ? s[96:49] : s[95:48])};
  endfunction

  task automatic chk_res(input string nm, input logic [59:0] e, input logic [59:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // apb transfer; one idle edge after it so psel is never driven twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clock);
  endtask

  // one start per call; start stays high so calls can run back to back
  task automatic issue(input fadr_op_t op, input logic dp, input logic sc, input logic take);
    logic [3:0] st;
    logic [59:0] w;
    w = model(op, dp, sc, st);
    i_start <= 1'b1;
    i_op <= op;
    i_double_precision_select <= dp;
    i_special_case <= sc;
    if (take) begin
      exp_q.push_back(w);
      iss_q.push_back(cyc);
      last_st = st;
      last_w = w;
      n_ops++;
    end
    @(posedge i_clock);
  endtask

  // destination side: each delivered word against the oldest pending one
  always @(posedge i_clock) begin
    if (o_result_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("CHECK FAILED result_valid expected 0 seen 1");
      end else begin
        chk_res("result", exp_q.pop_front(), o_result);
        chk_reg("latency", LAT + 1, cyc - iss_q.pop_front());
      end
    end
  end

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    ops[0] = {96'h0123_4567_89ab_cdef_0011_2233, 96'h0100_0000_0000_0000_0000_0001, 2'b00,
      11'h010};
    ops[1] = {96'hc000_0000_0000_0000_0000_0005, 96'h8000_0000_0000_0000_0000_0003, 2'b00,
      11'h010};
    ops[2] = {ops[1][204:11], `FADR_EXP_NEG_ONE};
    ops[3] = {96'hc000_0000_1234_0000_0000_0000, ~96'h8000_0000_0000_0000_0000_0007, 2'b01,
      11'h021};
    ops[4] = {96'h0000_0000_0000_1111_2222_3333, ~96'h0000_4444_0000_0000_0000_0001, 2'b01,
      11'h005};
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    chk_res("reset_result", 60'h0, o_result);
    apb(1'b0, `FADR_CTRL_OFS, 32'h0);
    chk_reg("ctrl_reset", `FADR_CTRL_RST, rd);
    apb(1'b0, 12'h014, 32'h0);
    chk_reg("unmapped_err", 32'h1, {31'h0, err});
    // every case in both precisions, back to back; 1-2 overflow, 3-4 unlike signs
    for (int i = 0; i < 5; i++) begin
      for (int p = 0; p < 2; p++) begin
        issue(ops[i], p[0], 1'b0, 1'b1);
      end
    end
    issue(ops[2], 1'b0, 1'b1, 1'b1);
    issue(ops[2], 1'b1, 1'b0, 1'b1);
    i_start <= 1'b0;
    repeat (LAT + 3) @(posedge i_clock);
    apb(1'b0, `FADR_STATUS_OFS, 32'h0);
    chk_reg("status", {28'h0, last_st}, rd);
    apb(1'b0, `FADR_RESLO_OFS, 32'h0);
    chk_reg("result_lo", last_w[31:0], rd);
    apb(1'b0, `FADR_RESHI_OFS, 32'h0);
    chk_reg("result_hi", {4'h0, last_w[59:32]}, rd);
    // disabled unit must drop the start without a word or a count
    apb(1'b1, `FADR_CTRL_OFS, 32'h0);
    issue(ops[0], 1'b0, 1'b0, 1'b0);
    i_start <= 1'b0;
    repeat (LAT + 3) @(posedge i_clock);
    apb(1'b0, `FADR_COUNT_OFS, 32'h0);
    chk_reg("count", n_ops, rd);
    apb(1'b1, `FADR_CTRL_OFS, 32'h1);
    chk_reg("pending", 32'h0, exp_q.size());
    chk_reg("dest_writes", n_ops, dest_writes);
    complete_run();
  end

  // whole run is under a hundred edges; this cuts a hang short
  initial begin
    repeat (3000) @(posedge i_clock);
    n_mismatch++;
    complete_run();
  end
endmodule
